// *** rtl/asc_defines.vh ***
// constants for the standby, calibration and power-off sequencer
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH
// ****************************************
// clock rates
// ****************************************
`define ASC_CORE_HZ100        2500000
`define ASC_CONV_HZ100        49152
`define ASC_INT_DIV           ((`ASC_CORE_HZ100 + (`ASC_CONV_HZ100 / 2)) / `ASC_CONV_HZ100)
// ****************************************
// times in their own units
// ****************************************
`define ASC_CAL_FAST_MS       103
`define ASC_CAL_SLOW_MS       803
`define ASC_PWR_OFF_US        26
`define ASC_WAKE_INT_NS       7950
`define ASC_WAKE_EXT_NS       160
`define ASC_STBY_ENTRY_US     20
// ****************************************
// counts of conversion clock ticks
// ****************************************
`define ASC_CAL_FAST_TICKS    (`ASC_CAL_FAST_MS * `ASC_CONV_HZ100 / 10)
`define ASC_CAL_SLOW_TICKS    (`ASC_CAL_SLOW_MS * `ASC_CONV_HZ100 / 10)
`define ASC_PWR_OFF_TICKS     ((`ASC_PWR_OFF_US * `ASC_CONV_HZ100 + 9999) / 10000)
`define ASC_WAKE_INT_TICKS    (`ASC_WAKE_INT_NS * `ASC_CONV_HZ100 / 10000000)
`define ASC_WAKE_EXT_RAW      (`ASC_WAKE_EXT_NS * `ASC_CONV_HZ100 / 10000000)
`define ASC_WAKE_EXT_TICKS    ((`ASC_WAKE_EXT_RAW < 1) ? 1 : `ASC_WAKE_EXT_RAW)
`define ASC_STBY_TICKS        ((`ASC_STBY_ENTRY_US * `ASC_CONV_HZ100 + 9999) / 10000)
// ****************************************
// readback framing and clock activity window
// ****************************************
`define ASC_DATA_BITS         20
`define ASC_CAL_PULSES        25
`define ASC_ACT_WINDOW        255
`endif

// *** rtl/asc_sync.v ***
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module asc_sync #(
  parameter W = 4
) (
  input  wire         core_clk_in,
  input  wire         sys_rst_in,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;   // first stage, read only by the second
  reg [W-1:0] sync_reg;   // second stage
  // ****************************************
  // two stages
  // ****************************************
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule // asc_sync
`default_nettype wire

// *** rtl/asc_timer.v ***
// down counter of conversion clock ticks with a done level
`timescale 1ns/1ps
`default_nettype none
module asc_timer #(
  parameter TW = 22
) (
  input  wire          core_clk_in,
  input  wire          sys_rst_in,
  input  wire          load_in,
  input  wire [TW-1:0] load_val_in,
  input  wire          clr_in,
  input  wire          tick_in,
  output wire          busy_out,
  output wire          done_out
);
  reg [TW-1:0] cnt_reg;    // ticks left
  reg          armed_reg;  // a count is running or has ended
  // ****************************************
  // count down on each tick
  // ****************************************
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in || clr_in)
    begin
      cnt_reg   <= {TW{1'b0}};
      armed_reg <= 1'b0;
    end
    else if (load_in)
    begin
      cnt_reg   <= load_val_in;
      armed_reg <= 1'b1;
    end
    else if (tick_in && (cnt_reg != {TW{1'b0}}))
    begin
      cnt_reg <= cnt_reg - {{(TW-1){1'b0}}, 1'b1};
    end
  end
  assign busy_out = armed_reg;
  assign done_out = armed_reg && (cnt_reg == {TW{1'b0}}) && !load_in;
endmodule // asc_timer
`default_nettype wire

// *** rtl/asc_power_ctrl.v ***
// standby, queued calibration and power-off sequencer of a pin-controlled converter
`include "asc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module asc_power_ctrl #(
  parameter TW             = 22,
  parameter CAL_FAST_TICKS = `ASC_CAL_FAST_TICKS,
  parameter CAL_SLOW_TICKS = `ASC_CAL_SLOW_TICKS,
  parameter INT_DIV        = `ASC_INT_DIV
) (
  input  wire        core_clk_in,
  input  wire        sys_rst_in,
  input  wire        serial_clk_in,
  input  wire        power_off_pin_in,
  input  wire        clock_input_pin_in,
  input  wire        speed_fast_in,
  input  wire        conv_valid_in,
  input  wire [19:0] conv_data_in,
  output reg         ready_and_data_line_out,
  output wire        analog_on_out,
  output wire        cal_busy_out,
  output wire        standby_out,
  output wire        conv_reset_out,
  output wire        ext_clock_out,
  output wire        conv_tick_out
);
  // ****************************************
  // states and constants
  // ****************************************
  localparam [2:0] ST_OFF  = 3'h0;   // power-off pin low
  localparam [2:0] ST_WAKE = 3'h1;   // waking after release
  localparam [2:0] ST_RUN  = 3'h2;   // converting and reading back
  localparam [2:0] ST_STBY = 3'h3;   // standby
  localparam [2:0] ST_CAL  = 3'h4;   // calibration after wake-up
  localparam integer WAKE_INT = `ASC_WAKE_INT_TICKS;
  localparam integer WAKE_EXT = `ASC_WAKE_EXT_TICKS;
  localparam integer STBY_T   = `ASC_STBY_TICKS;
  localparam integer PWR_OFF  = `ASC_PWR_OFF_TICKS;
  localparam integer ACT_WIN  = `ASC_ACT_WINDOW;
  localparam integer CAL_PUL  = `ASC_CAL_PULSES;   // full pulses before the rise that holds

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [3:0] pins_s;        // synchronised pin levels
  wire       sclk_s;        // serial clock
  wire       poff_n_s;      // power-off pin, low asserts
  wire       clkpin_s;      // clock input pin
  wire       fast_s;        // rate setting
  asc_sync #(.W(4)) u_sync (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .async_in    ({speed_fast_in, clock_input_pin_in, power_off_pin_in, serial_clk_in}),
    .sync_out    (pins_s)
  );
  assign sclk_s   = pins_s[0];
  assign poff_n_s = pins_s[1];
  assign clkpin_s = pins_s[2];
  assign fast_s   = pins_s[3];
  // ****************************************
  // clock source detection
  // ****************************************
  reg       clkpin_d_reg;   // last clock pin level
  reg [7:0] act_cnt_reg;    // cycles since last clock pin edge
  reg       ext_reg;        // external clock present
  wire      clk_rise;       // rising edge on clock pin
  assign clk_rise = clkpin_s && !clkpin_d_reg;
  // clock source survives power-off, like the real clock circuitry
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      clkpin_d_reg <= 1'b0;
      act_cnt_reg  <= 8'hff;
      ext_reg      <= 1'b0;
    end
    else
    begin
      clkpin_d_reg <= clkpin_s;
      if (clkpin_s != clkpin_d_reg)
        act_cnt_reg <= 8'h00;
      else if (act_cnt_reg != 8'hff)
        act_cnt_reg <= act_cnt_reg + 8'h01;
      ext_reg <= (act_cnt_reg < ACT_WIN[7:0]);
    end
  end

  // ****************************************
  // conversion clock tick
  // ****************************************
  reg [7:0] div_reg;        // internal oscillator divider
  wire      int_tick;       // internal oscillator tick
  assign int_tick = (div_reg == INT_DIV[7:0] - 8'h01);
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in || int_tick)
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end
  // wake-up, standby entry, calibration and power-off width count these ticks, so they follow the clock period
  assign conv_tick_out = ext_reg ? clk_rise : int_tick;
  assign ext_clock_out = ext_reg;
  // ****************************************
  // power-off acts as a reset of all sequencing
  // ****************************************
  wire rst_all;             // reset or power-off pin low
  assign rst_all = sys_rst_in || !poff_n_s;
  // ****************************************
  // state registers
  // ****************************************
  reg [2:0]  state_reg;     // sequencer state
  reg [2:0]  state_next;
  reg [19:0] shift_reg;     // readback shifter
  reg [19:0] hold_reg;      // latest conversion result
  reg [4:0]  pulse_reg;     // serial clock pulses since ready
  reg        ready_seen_reg; // ready was signalled
  reg        cal_q_reg;     // calibration queued for wake-up
  reg        sclk_d_reg;    // last serial clock level
  reg [7:0]  off_cnt_reg;   // power-off pulse width in ticks
  reg        off_ok_reg;    // pulse met its least width
  wire       sclk_rise;     // serial clock rising edge
  assign sclk_rise = sclk_s && !sclk_d_reg;
  // ****************************************
  // shared timer
  // ****************************************
  reg          tmr_load;    // start a count
  reg [TW-1:0] tmr_val;     // count to start
  reg          tmr_clr;     // cancel the count
  wire         tmr_busy;    // a count is armed
  wire         tmr_done;    // count has ended
  wire [TW-1:0] cal_fast_w; // fast rate calibration count
  wire [TW-1:0] cal_slow_w; // slow rate calibration count
  assign cal_fast_w = CAL_FAST_TICKS[TW-1:0];
  assign cal_slow_w = CAL_SLOW_TICKS[TW-1:0];
  asc_timer #(.TW(TW)) u_tmr (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (rst_all),
    .load_in     (tmr_load),
    .load_val_in (tmr_val),
    .clr_in      (tmr_clr),
    .tick_in     (conv_tick_out),
    .busy_out    (tmr_busy),
    .done_out    (tmr_done)
  );

  // ****************************************
  // next state and timer control
  // ****************************************
  always @*
  begin
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_val    = {TW{1'b0}};
    tmr_clr    = 1'b0;
    case (state_reg)
      ST_OFF:
      begin
        // pin already high here, so start the wake-up count
        state_next = ST_WAKE;
        tmr_load   = 1'b1;
        tmr_val    = ext_reg ? WAKE_EXT[TW-1:0] : WAKE_INT[TW-1:0];
      end
      ST_WAKE:
      begin
        if (tmr_done)
        begin
          state_next = ST_RUN;
          tmr_clr    = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (!sclk_s)
          tmr_clr = 1'b1;
        else if (ready_seen_reg && !tmr_busy)
        begin
          tmr_load = 1'b1;
          tmr_val  = STBY_T[TW-1:0];
        end
        else if (tmr_done)
        begin
          state_next = ST_STBY;
          tmr_clr    = 1'b1;
        end
      end
      ST_STBY:
      begin
        if (!sclk_s)
        begin
          // low serial clock wakes the device
          if (cal_q_reg)
          begin
            state_next = ST_CAL;
            tmr_load   = 1'b1;
            tmr_val    = fast_s ? cal_fast_w : cal_slow_w;
          end
          else
            state_next = ST_RUN;
        end
      end
      ST_CAL:
      begin
        if (tmr_done)
        begin
          state_next = ST_RUN;
          tmr_clr    = 1'b1;
        end
      end
      default:
      begin
        state_next = ST_OFF;
      end
    endcase
  end

  // ****************************************
  // sequencer, readback and data line
  // ****************************************
  always @(posedge core_clk_in)
  begin
    if (rst_all)
    begin
      // everything cleared while the pin is low, even mid readback
      state_reg               <= ST_OFF;
      shift_reg               <= 20'h00000;
      hold_reg                <= 20'h00000;
      pulse_reg               <= 5'h00;
      ready_seen_reg          <= 1'b0;
      cal_q_reg               <= 1'b0;
      sclk_d_reg              <= 1'b1;
      ready_and_data_line_out <= 1'b1;
    end
    else
    begin
      state_reg  <= state_next;
      sclk_d_reg <= sclk_s;
      if (conv_valid_in && state_reg == ST_RUN)
        hold_reg <= conv_data_in;
      case (state_reg)
        ST_RUN:
        begin
          if (conv_valid_in)
          begin
            // new result: line low, readback restarts
            shift_reg               <= conv_data_in;
            pulse_reg               <= 5'h00;
            ready_seen_reg          <= 1'b1;
            ready_and_data_line_out <= 1'b0;
          end
          else if (sclk_rise)
          begin
            // msb first, ones fill in behind the result
            ready_and_data_line_out <= shift_reg[19];
            shift_reg               <= {shift_reg[18:0], 1'b1};
            if (pulse_reg != 5'h1f)
              pulse_reg <= pulse_reg + 5'h01;
          end
          if (state_next == ST_STBY)
          begin
            cal_q_reg               <= (pulse_reg == CAL_PUL[4:0] + 5'h01);
            ready_and_data_line_out <= 1'b1;
            ready_seen_reg          <= 1'b0;
          end
        end
        ST_STBY:
        begin
          ready_and_data_line_out <= 1'b1;
          pulse_reg               <= 5'h00;
        end
        ST_CAL:
        begin
          if (state_next == ST_RUN)
          begin
            // settled result offered at once, nothing to discard
            shift_reg               <= hold_reg;
            ready_and_data_line_out <= 1'b0;
            ready_seen_reg          <= 1'b1;
            cal_q_reg               <= 1'b0;
            pulse_reg               <= 5'h00;
          end
        end
        default:
        begin
          ready_and_data_line_out <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // power-off pulse width monitor
  // ****************************************
  // the host keeps the pin low through supply ramp; conv_reset_out stays high until one pulse has met the least width
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      off_cnt_reg <= 8'h00;
      off_ok_reg  <= 1'b0;
    end
    else if (poff_n_s)
    begin
      off_cnt_reg <= 8'h00;
    end
    else if (conv_tick_out && off_cnt_reg != 8'hff)
    begin
      off_cnt_reg <= off_cnt_reg + 8'h01;
      if (off_cnt_reg + 8'h01 >= PWR_OFF[7:0])
        off_ok_reg <= 1'b1;
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  assign analog_on_out  = (state_reg == ST_RUN) || (state_reg == ST_CAL);
  assign cal_busy_out   = (state_reg == ST_CAL);
  assign standby_out    = (state_reg == ST_STBY);
  assign conv_reset_out = rst_all || (state_reg == ST_OFF) || (state_reg == ST_WAKE) ||
                          (state_reg == ST_CAL) || !off_ok_reg;
endmodule // asc_power_ctrl
`default_nettype wire

// *** tb/asc_power_ctrl_sva.sv ***
// port assertions for the standby, calibration and power-off sequencer
`timescale 1ns/1ps
`default_nettype none
module asc_power_ctrl_sva #(
  parameter TW             = 22,
  parameter CAL_FAST_TICKS = 20,
  parameter CAL_SLOW_TICKS = 40,
  parameter INT_DIV        = 51
) (
  input wire        core_clk_in,
  input wire        sys_rst_in,
  input wire        serial_clk_in,
  input wire        power_off_pin_in,
  input wire        clock_input_pin_in,
  input wire        speed_fast_in,
  input wire        conv_valid_in,
  input wire [19:0] conv_data_in,
  input wire        ready_and_data_line_out,
  input wire        analog_on_out,
  input wire        cal_busy_out,
  input wire        standby_out,
  input wire        conv_reset_out,
  input wire        ext_clock_out,
  input wire        conv_tick_out
);
  // ****************************************
  // helper logic
  // ****************************************
  reg [TW-1:0] cal_ticks_reg; // conversion ticks seen while calibrating
  // count ticks only while calibration runs
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in || !cal_busy_out)
      cal_ticks_reg <= {TW{1'b0}};
    else if (conv_tick_out)
      cal_ticks_reg <= cal_ticks_reg + 1'b1;
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_off_clears_all: assert property ((!power_off_pin_in)[*3] |=>
    ready_and_data_line_out && !analog_on_out && !standby_out && !cal_busy_out && conv_reset_out)
    else $error("power-off did not clear the sequencer");
  a_stby_line_high: assert property (standby_out |-> ready_and_data_line_out)
    else $error("data line low in standby");
  a_cal_state_ok: assert property (cal_busy_out |-> analog_on_out && !standby_out && conv_reset_out)
    else $error("bad outputs during calibration");
  a_cal_end_low: assert property ($fell(cal_busy_out) && power_off_pin_in && $past(power_off_pin_in, 3)
    |-> ##[0:1] !ready_and_data_line_out) else $error("no data ready after calibration");
  a_cal_tick_len: assert property ($fell(cal_busy_out) && power_off_pin_in && $past(power_off_pin_in, 3)
    |-> cal_ticks_reg + 1 >= (speed_fast_in ? CAL_FAST_TICKS : CAL_SLOW_TICKS)
    && cal_ticks_reg <= (speed_fast_in ? CAL_FAST_TICKS : CAL_SLOW_TICKS) + 2)
    else $error("calibration length wrong");
  a_ready_on_new: assert property (conv_valid_in && analog_on_out && !cal_busy_out && power_off_pin_in
    && $past(power_off_pin_in, 2) |=> !ready_and_data_line_out) else $error("new result not flagged");
  a_stby_exit: assert property (standby_out ##1 (!serial_clk_in)[*6] |=> !standby_out)
    else $error("standby held with serial clock low");
  a_int_tick_gap: assert property (!ext_clock_out && conv_tick_out |=> (!conv_tick_out)[*8])
    else $error("internal tick too close");
  a_wake_ext: assert property ($rose(power_off_pin_in) && ext_clock_out && !analog_on_out
    |-> ##[1:40] analog_on_out) else $error("slow wake on external clock");
endmodule // asc_power_ctrl_sva
bind asc_power_ctrl asc_power_ctrl_sva #(.TW(TW), .CAL_FAST_TICKS(CAL_FAST_TICKS),
  .CAL_SLOW_TICKS(CAL_SLOW_TICKS), .INT_DIV(INT_DIV)) u_sva (.core_clk_in(core_clk_in),
  .sys_rst_in(sys_rst_in), .serial_clk_in(serial_clk_in), .power_off_pin_in(power_off_pin_in),
  .clock_input_pin_in(clock_input_pin_in), .speed_fast_in(speed_fast_in), .conv_valid_in(conv_valid_in),
  .conv_data_in(conv_data_in), .ready_and_data_line_out(ready_and_data_line_out),
  .analog_on_out(analog_on_out), .cal_busy_out(cal_busy_out), .standby_out(standby_out),
  .conv_reset_out(conv_reset_out), .ext_clock_out(ext_clock_out), .conv_tick_out(conv_tick_out));
`default_nettype wire

// *** tb/asc_host_model.sv ***
// host model driving the serial clock and the power-off pin
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
  input  wire  core_clk_in,
  input  wire  line_in,
  output logic serial_clk_out,
  output logic power_off_pin_out
);
  // pin low from time zero until supplies are up
  initial
  begin
    serial_clk_out    = 1'b0;
    power_off_pin_out = 1'b0;
  end
  // one full serial clock pulse, bit sampled mid high phase
  task automatic pulse(output logic b);
    serial_clk_out = 1'b1;
    repeat (12) @(posedge core_clk_in);
    #1 b = line_in;
    repeat (13) @(posedge core_clk_in);
    #1 serial_clk_out = 1'b0;
    repeat (25) @(posedge core_clk_in);
    #1;
  endtask
  // n pulses, bits not looked at
  task automatic pulses(input int n);
    logic b;
    repeat (n) pulse(b);
  endtask
  // hold serial clock at a level: high keeps standby, low wakes
  task automatic sclk_level(input logic v);
    serial_clk_out = v;
  endtask
  // power-off pin low for n cycles, then back high
  task automatic power_off(input int n);
    power_off_pin_out = 1'b0;
    repeat (n) @(posedge core_clk_in);
    #1 power_off_pin_out = 1'b1;
  endtask
endmodule // asc_host_model
`default_nettype wire

// *** tb/asc_power_ctrl_tb_top.sv ***
// self-checking bench of the power sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("FAIL %s exp %h got %h", nm, e, a); end end
`define WAITF(c, n) begin for (int k = 0; k < (n) && !(c); k++) begin @(posedge core_clk_in); #1; end end
module asc_power_ctrl_tb_top;
  localparam int FT = 20; // shortened fast calibration ticks
  localparam int ST = 40; // shortened slow calibration ticks
  logic        core_clk_in; // core clock
  logic        sys_rst_in;  // sync reset
  logic        clk_pin;     // external conversion clock
  logic        ext_en;      // external clock running
  logic        speed;       // rate select
  logic        valid;       // new result strobe
  logic [19:0] data;        // result value
  wire         sclk, pin, line, aon, cal, stby, crst, extc, tick;
  int          failures = 0; // mismatches
  int          total_checks = 0; // comparisons
  logic        b; // bit read back
  typedef struct { logic [19:0] d; int n; } row_t;
  row_t rows [3] = '{'{20'h80001, 24}, '{20'h5a5a5, 20}, '{20'h00000, 22}};
  // ****************************************
  // clocks, partner and design
  // ****************************************
  always #2 core_clk_in = ~core_clk_in;
  initial #3 forever #16 clk_pin = ext_en ? ~clk_pin : 1'b0;
  asc_host_model host (.core_clk_in(core_clk_in), .line_in(line), .serial_clk_out(sclk), .power_off_pin_out(pin));
  asc_power_ctrl #(.CAL_FAST_TICKS(FT), .CAL_SLOW_TICKS(ST)) dut (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .serial_clk_in(sclk), .power_off_pin_in(pin), .clock_input_pin_in(clk_pin),
    .speed_fast_in(speed), .conv_valid_in(valid), .conv_data_in(data), .ready_and_data_line_out(line),
    .analog_on_out(aon), .cal_busy_out(cal), .standby_out(stby), .conv_reset_out(crst),
    .ext_clock_out(extc), .conv_tick_out(tick));
  // ****************************************
  // tasks
  // ****************************************
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hand one result to the sequencer and see it flagged
  task automatic send(input logic [19:0] v);
    @(posedge core_clk_in) #1 valid = 1'b1;
    data = v;
    @(posedge core_clk_in) #1 valid = 1'b0;
    @(posedge core_clk_in) #1 `CHK("ready", 1'b0, line)
  endtask
  // read n bits and compare, ones past the result
  task automatic read(input logic [19:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      host.pulse(b);
      `CHK("bit", (i < 20) ? v[19-i] : 1'b1, b)
    end
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial #400000 begin failures++; test_done(); end
  initial
  begin
    int n;
    core_clk_in = 1'b0;
    sys_rst_in  = 1'b1;
    clk_pin     = 1'b0;
    ext_en      = 1'b1;
    speed       = 1'b1;
    valid       = 1'b0;
    data        = 20'h00000;
    repeat (5) @(posedge core_clk_in);
    #1 `CHK("line in reset", 1'b1, line)
    `CHK("analog in reset", 1'b0, aon)
    sys_rst_in = 1'b0;
    host.power_off(1100);
    `WAITF(aon, 60)
    `CHK("wake ext", 1'b1, aon)
    `CHK("conv reset", 1'b0, crst)
    // one conversion tick per external clock period of eight core cycles
    n = 0;
    repeat (80) begin @(posedge core_clk_in); #1; n += (tick === 1'b1); end
    `CHK("ticks", 10, n)
    `CHK("ext clock", 1'b1, extc)
    foreach (rows[r])
    begin
      send(rows[r].d);
      read(rows[r].d, rows[r].n);
    end
    for (int s = 1; s >= 0; s--)
    begin
      speed = s[0];
      send(20'habcde);
      host.pulses(25);
      host.sclk_level(1'b1);
      `WAITF(stby, 1000)
      `CHK("standby", 1'b1, stby)
      `CHK("stby line", 1'b1, line)
      host.sclk_level(1'b0);
      `WAITF(cal, 20)
      `CHK("cal run", 1'b1, cal)
      n = 0;
      while (cal === 1'b1 && n < 2000) begin @(posedge core_clk_in); #1; n++; end
      #1 `CHK("cal ready", 1'b0, line)
      `CHK("cal len", 1'b1, n >= (s ? FT : ST) * 8 - 16 && n <= (s ? FT : ST) * 8 + 24)
      read(20'habcde, 20);
    end
    send(20'h12345);
    host.pulses(20);
    host.sclk_level(1'b1);
    `WAITF(stby, 1000)
    `CHK("plain stby", 1'b1, stby)
    host.sclk_level(1'b0);
    repeat (30) @(posedge core_clk_in);
    #1 `CHK("no cal", 1'b0, cal)
    `CHK("awake", 1'b1, aon)
    send(20'hfffff);
    read(20'hfffff, 5);
    host.power_off(10);
    `CHK("off line", 1'b1, line)
    `CHK("off analog", 1'b0, aon)
    `WAITF(aon, 60)
    `CHK("rewake", 1'b1, aon)
    ext_en = 1'b0;
    repeat (400) @(posedge core_clk_in);
    #1 `CHK("int clock", 1'b0, extc)
    host.power_off(300);
    repeat (1500) @(posedge core_clk_in);
    #1 `CHK("int early", 1'b0, aon)
    `WAITF(aon, 1500)
    `CHK("int wake", 1'b1, aon)
    test_done();
  end
endmodule // asc_power_ctrl_tb_top
`default_nettype wire
